//--- src/pmc_defs.svh
// Offsets, field positions, reset values and codes of the product-term macrocell block
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ==========================================================
// Register byte addresses
`define PMC_CTRL_ADDR      12'h000
`define PMC_STATUS_ADDR    12'h004
`define PMC_QSTATE_ADDR    12'h008
`define PMC_CFG_BASE       12'h100
`define PMC_MASK_BASE      12'h200

// ==========================================================
// Block control register fields
`define PMC_CTRL_CE_BIT    0
`define PMC_CTRL_C0SRC_BIT 1
`define PMC_CTRL_C0INV_BIT 2
`define PMC_CTRL_C1SRC_BIT 3
`define PMC_CTRL_C1INV_BIT 4
`define PMC_CTRL_W         5
`define PMC_CTRL_RST       5'h01

// ==========================================================
// Per-macrocell configuration fields
`define PMC_CFG_REG_BIT    0
`define PMC_CFG_LEND0_BIT  1
`define PMC_CFG_LEND1_BIT  2
`define PMC_CFG_INV0_BIT   3
`define PMC_CFG_BORROW_BIT 4
`define PMC_CFG_CHAIN_BIT  5
`define PMC_CFG_PRESET_BIT 6
`define PMC_CFG_CSEL_LSB   7
`define PMC_CFG_W          9
`define PMC_CFG_RST        9'h000

// ==========================================================
// Clear select codes and mask reset
`define PMC_CSEL_NONE      2'h0
`define PMC_CSEL_A         2'h1
`define PMC_CSEL_B         2'h2
`define PMC_MASK_RST       32'h0000_0000

// ==========================================================
// Expander chain limit
`define PMC_EXP_SET_MAX    15

`endif

//--- src/pmc_pkg.sv
// Types shared by the product-term macrocell block
package pmc_pkg;

  // Clear choice of one macrocell
  typedef enum logic [1:0] {
    PMC_CLR_NONE,
    PMC_CLR_A,
    PMC_CLR_B
  } pmc_clr_sel_t;

  // Decoded configuration of one macrocell
  typedef struct packed {
    pmc_clr_sel_t clr_sel;
    logic         preset_emul;
    logic         chain_en;
    logic         borrow_en;
    logic         inv0;
    logic         lend1;
    logic         lend0;
    logic         registered;
  } pmc_mc_cfg_t;

  // Kind of register hit by an APB address
  typedef enum logic [2:0] {
    PMC_HIT_CTRL,
    PMC_HIT_STATUS,
    PMC_HIT_QSTATE,
    PMC_HIT_CFG,
    PMC_HIT_MASK,
    PMC_HIT_NONE
  } pmc_hit_t;

endpackage

//--- src/pmc_pterm.sv
// Two product terms of one macrocell, the first one invertible
`timescale 1ns/1ps
module pmc_pterm
  import pmc_pkg::*;
#(
  parameter int IN_W = 16
) (
  // Term inputs
  input  wire logic [IN_W-1:0] lin_i,
  input  wire logic [IN_W-1:0] mask0_i,
  input  wire logic [IN_W-1:0] mask1_i,
  input  wire logic            inv0_i,
  // Terms
  output logic                 pt0_o,
  output logic                 pt1_o
);

  logic raw0;
  logic raw1;

  // An empty mask gives an inactive term, not a constant one
  assign raw0 = (|mask0_i) & (&(lin_i | ~mask0_i));
  assign raw1 = (|mask1_i) & (&(lin_i | ~mask1_i));

  // Only the first term has an inverter
  assign pt0_o = raw0 ^ inv0_i;
  assign pt1_o = raw1;

endmodule

//--- src/pmc_mreg.sv
// Programmable macrocell register with clock enable and asynchronous clear
`timescale 1ns/1ps
module pmc_mreg (
  // Clock and controls
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic aclr_i,
  input  wire logic ce_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);

  // Clear forces zero at once, capture only on enabled edges
  always_ff @(posedge clk_sys_i or posedge aclr_i) begin
    if (aclr_i) begin
      q_o <= 1'b0;
    end else if (rst_i) begin
      q_o <= 1'b0;
    end else if (ce_i) begin
      q_o <= d_i;
    end
  end

endmodule

//--- src/pmc_block.sv
// Product-term array of an embedded_array_block with APB configuration
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_block
  import pmc_pkg::*;
#(
  parameter int MC_N = 16,
  parameter int IN_W = 16
) (
  // Clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  // APB slave
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [11:0]     paddr_i,
  input  wire logic [31:0]     pwdata_i,
  output logic [31:0]          prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  // Local interconnect and global signals
  input  wire logic [IN_W-1:0] lin_i,
  input  wire logic [1:0]      lclr_i,
  input  wire logic [1:0]      gclr_i,
  input  wire logic            clken_i,
  // Macrocell outputs
  output logic [MC_N-1:0]      mc_out_o
);

  // ==========================================================
  // Address decoding

  localparam int MASK_N      = 2 * MC_N;
  // Expander sets that one macrocell may borrow through the chain
  localparam int EXP_SET_MAX = `PMC_EXP_SET_MAX;

  // Maps a byte address to a register kind and an index
  function automatic pmc_hit_t pmc_decode(input logic [11:0] addr, output int idx);
    int off;
    pmc_hit_t hit;
    hit = PMC_HIT_NONE;
    idx = 0;
    off = 0;
    if (addr[1:0] == 2'h0) begin
      if (addr == `PMC_CTRL_ADDR) begin
        hit = PMC_HIT_CTRL;
      end else if (addr == `PMC_STATUS_ADDR) begin
        hit = PMC_HIT_STATUS;
      end else if (addr == `PMC_QSTATE_ADDR) begin
        hit = PMC_HIT_QSTATE;
      end else if (addr >= `PMC_CFG_BASE && addr < `PMC_CFG_BASE + 12'(4 * MC_N)) begin
        off = int'(addr - `PMC_CFG_BASE);
        idx = off / 4;
        hit = PMC_HIT_CFG;
      end else if (addr >= `PMC_MASK_BASE && addr < `PMC_MASK_BASE + 12'(4 * MASK_N)) begin
        off = int'(addr - `PMC_MASK_BASE);
        idx = off / 4;
        hit = PMC_HIT_MASK;
      end
    end
    return hit;
  endfunction

  // Unpacks a configuration word into its fields
  function automatic pmc_mc_cfg_t pmc_unpack(input logic [`PMC_CFG_W-1:0] w);
    pmc_mc_cfg_t c;
    c.registered  = w[`PMC_CFG_REG_BIT];
    c.lend0       = w[`PMC_CFG_LEND0_BIT];
    c.lend1       = w[`PMC_CFG_LEND1_BIT];
    c.inv0        = w[`PMC_CFG_INV0_BIT];
    c.borrow_en   = w[`PMC_CFG_BORROW_BIT];
    c.chain_en    = w[`PMC_CFG_CHAIN_BIT];
    c.preset_emul = w[`PMC_CFG_PRESET_BIT];
    case (w[`PMC_CFG_CSEL_LSB +: 2])
      `PMC_CSEL_A: c.clr_sel = PMC_CLR_A;
      `PMC_CSEL_B: c.clr_sel = PMC_CLR_B;
      default:     c.clr_sel = PMC_CLR_NONE;
    endcase
    return c;
  endfunction

  // ==========================================================
  // Chain and clear helpers

  // Lent sets reaching macrocell pos through chained stages, nearest first
  function automatic logic pmc_chain_in(input logic [MC_N-1:0] lent_v,
                                        input logic [MC_N-1:0] pass_v,
                                        input int              pos);
    logic acc;
    logic reach;
    acc   = 1'b0;
    reach = 1'b1;
    for (int k = 1; k <= EXP_SET_MAX; k++) begin
      if (pos - k >= 0) begin
        acc   = acc | (reach & lent_v[pos - k]);
        reach = reach & pass_v[pos - k];
      end
    end
    return acc;
  endfunction

  // Source pick, then the polarity flip of one shared clear
  function automatic logic pmc_clear(input logic use_local, input logic flip,
                                     input logic from_local, input logic from_global);
    return (use_local ? from_local : from_global) ^ flip;
  endfunction

  // ==========================================================
  // Configuration storage

  logic [`PMC_CTRL_W-1:0] ctrl;
  logic [`PMC_CFG_W-1:0]  cfg_mem  [MC_N];
  logic [IN_W-1:0]        mask_mem [MASK_N];
  logic [MC_N-1:0]        q_vec;

  pmc_hit_t req_hit;
  int       req_idx;
  logic     wr_fire;
  logic     wr_ctrl;
  logic     wr_cfg;
  logic     wr_mask;

  always_comb begin
    req_hit = pmc_decode(paddr_i, req_idx);
  end

  // A write takes effect at the access edge only
  assign wr_fire = psel_i & penable_i & pready_o & pwrite_i;

  // Write strobes per register kind
  assign wr_ctrl = wr_fire & (req_hit == PMC_HIT_CTRL);
  assign wr_cfg  = wr_fire & (req_hit == PMC_HIT_CFG);
  assign wr_mask = wr_fire & (req_hit == PMC_HIT_MASK);

  // Block control register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl <= `PMC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= pwdata_i[`PMC_CTRL_W-1:0];
    end
  end

  // Macrocell configuration words
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < MC_N; i++) begin
        cfg_mem[i] <= `PMC_CFG_RST;
      end
    end else if (wr_cfg) begin
      cfg_mem[req_idx] <= pwdata_i[`PMC_CFG_W-1:0];
    end
  end

  // Product-term input masks, two per macrocell
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < MASK_N; i++) begin
        mask_mem[i] <= IN_W'(`PMC_MASK_RST);
      end
    end else if (wr_mask) begin
      mask_mem[req_idx] <= pwdata_i[IN_W-1:0];
    end
  end

  // ==========================================================
  // APB answer: data and status prepared in the setup cycle

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (req_hit)
      PMC_HIT_CTRL:   next_prdata[`PMC_CTRL_W-1:0] = ctrl;
      PMC_HIT_STATUS: next_prdata[MC_N-1:0] = mc_out_o;
      PMC_HIT_QSTATE: next_prdata[MC_N-1:0] = q_vec;
      PMC_HIT_CFG:    next_prdata[`PMC_CFG_W-1:0] = cfg_mem[req_idx];
      PMC_HIT_MASK:   next_prdata[IN_W-1:0] = mask_mem[req_idx];
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase after each setup cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & (req_hit == PMC_HIT_NONE);
      if (psel_i && !penable_i) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // ==========================================================
  // Shared clears

  logic clr_a;
  logic clr_b;
  logic reg_ce;

  // Source pick, then a polarity flip for each clear
  assign clr_a = pmc_clear(ctrl[`PMC_CTRL_C0SRC_BIT], ctrl[`PMC_CTRL_C0INV_BIT],
                           lclr_i[0], gclr_i[0]);
  assign clr_b = pmc_clear(ctrl[`PMC_CTRL_C1SRC_BIT], ctrl[`PMC_CTRL_C1INV_BIT],
                           lclr_i[1], gclr_i[1]);

  // Block-wide clock enable for all macrocell registers
  assign reg_ce = ctrl[`PMC_CTRL_CE_BIT] & clken_i;

  // ==========================================================
  // Macrocells and the parallel expander chain

  logic [MC_N-1:0] lent_vec;
  logic [MC_N-1:0] pass_vec;
  logic [MC_N-1:0] comb_val;
  logic [MC_N-1:0] next_mc_out;

  for (genvar g = 0; g < MC_N; g++) begin : g_mc
    pmc_mc_cfg_t c;
    logic        pt0;
    logic        pt1;
    logic        own_or;
    logic        lent;
    logic        borrow_in;
    logic        sum;
    logic        d;
    logic        aclr;

    assign c = pmc_unpack(cfg_mem[g]);

    pmc_pterm #(
      .IN_W (IN_W)
    ) pmc_pterm_inst (
      .lin_i   (lin_i),
      .mask0_i (mask_mem[2*g]),
      .mask1_i (mask_mem[2*g+1]),
      .inv0_i  (c.inv0),
      .pt0_o   (pt0),
      .pt1_o   (pt1)
    );

    // Each term goes to the own gate or out as expander
    assign own_or = (pt0 & ~c.lend0) | (pt1 & ~c.lend1);
    assign lent   = (pt0 & c.lend0) | (pt1 & c.lend1);

    // One set of up to two lent terms per stage, passed on when chained
    assign lent_vec[g] = lent;
    assign pass_vec[g] = c.chain_en;

    // Borrowed expanders join the OR gate straight from the chain
    assign borrow_in   = pmc_chain_in(lent_vec, pass_vec, g);
    assign sum         = own_or | (c.borrow_en & borrow_in);
    assign comb_val[g] = sum;

    // Inverted data into the register so a clear reads as a set
    assign d = sum ^ c.preset_emul;

    // Clear choice per macrocell
    assign aclr = (c.clr_sel == PMC_CLR_A) ? clr_a :
                  (c.clr_sel == PMC_CLR_B) ? clr_b : 1'b0;

    pmc_mreg pmc_mreg_inst (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .aclr_i    (aclr),
      .ce_i      (reg_ce),
      .d_i       (d),
      .q_o       (q_vec[g])
    );

    // Registered or combinational path, preset inversion undone
    assign next_mc_out[g] = c.registered ? (q_vec[g] ^ c.preset_emul)
                                         : comb_val[g];
  end

  // ==========================================================
  // Output stage

  // Every macrocell output leaves through a flip-flop
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mc_out_o <= {MC_N{1'b0}};
    end else begin
      mc_out_o <= next_mc_out;
    end
  end

endmodule

//--- dv/pmc_block_monitor.sv
// Checker for the APB side and output steadiness of the macrocell block
`timescale 1ns/1ps
module pmc_block_monitor #(
  parameter int MC_N = 16,
  parameter int IN_W = 16
) (
  // Clock and reset
  input wire logic            clk_sys_i,
  input wire logic            rst_i,
  // APB
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pwrite_i,
  input wire logic [11:0]     paddr_i,
  input wire logic [31:0]     pwdata_i,
  input wire logic [31:0]     prdata_o,
  input wire logic            pready_o,
  input wire logic            pslverr_o,
  // Fabric side
  input wire logic [IN_W-1:0] lin_i,
  input wire logic [1:0]      lclr_i,
  input wire logic [1:0]      gclr_i,
  input wire logic            clken_i,
  input wire logic [MC_N-1:0] mc_out_o
);
  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_ready_after_setup:
    assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  a_ready_in_access:
    assert property (pready_o |-> psel_i && penable_i) else $error("ready outside access");
  a_ready_single:
    assert property (pready_o |=> !pready_o) else $error("ready held too long");
  a_err_misalign:
    assert property (psel_i && !penable_i && paddr_i[1:0] != 2'h0 |=> pslverr_o)
      else $error("misaligned access not refused");
  a_err_unmapped:
    assert property (psel_i && !penable_i && paddr_i == 12'hFFC |=> pslverr_o)
      else $error("unmapped access not refused");
  a_err_with_ready:
    assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_err_read_zero:
    assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("refused read returned data");
  a_out_steady:
    assert property ((!psel_i && $stable(lin_i) && $stable({lclr_i, gclr_i, clken_i}))[*4]
      |-> $stable(mc_out_o)) else $error("outputs moved with quiet inputs");
endmodule
bind pmc_block pmc_block_monitor #(.MC_N(MC_N), .IN_W(IN_W)) pmc_block_monitor_inst (.*);

//--- dv/pmc_nbr_model.sv
// Neighbouring fabric: term inputs, clear sources and clock enable
`timescale 1ns/1ps
module pmc_nbr_model #(
  parameter int IN_W = 16
) (
  // Clock
  input  wire logic       clk_sys_i,
  // Fabric levels
  output logic [IN_W-1:0] lin_o,
  output logic [1:0]      lclr_o,
  output logic [1:0]      gclr_o,
  output logic            clken_o
);
  // Quiet levels at time zero
  initial begin
    lin_o = '0;
    lclr_o = 2'h0;
    gclr_o = 2'h0;
    clken_o = 1'b1;
  end
  // New levels just after a rising edge, held until the next call
  task automatic put(input logic [IN_W-1:0] l, input logic [1:0] lc, input logic [1:0] gc,
                     input logic ce);
    @(posedge clk_sys_i);
    lin_o <= l;
    lclr_o <= lc;
    gclr_o <= gc;
    clken_o <= ce;
  endtask
endmodule

//--- dv/pmc_block_tb_top.sv
// Self-checking bench for the product-term macrocell block
`timescale 1ns/1ps
module pmc_block_tb_top;
  localparam int MC_N = 16;
  localparam int IN_W = 16;
  // Bench signals
  logic            clk_sys_i;
  logic            rst_i;
  logic            psel_i;
  logic            penable_i;
  logic            pwrite_i;
  logic [11:0]     paddr_i;
  logic [31:0]     pwdata_i;
  logic [31:0]     prdata_o;
  logic            pready_o;
  logic            pslverr_o;
  logic [IN_W-1:0] lin_i;
  logic [1:0]      lclr_i;
  logic [1:0]      gclr_i;
  logic            clken_i;
  logic [MC_N-1:0] mc_out_o;
  logic [31:0]     rd_data;
  logic            rd_err;
  int              failures = 0;
  int              check_count = 0;
  int              cycles = 0;

  pmc_block #(.MC_N(MC_N), .IN_W(IN_W)) pmc_block_inst (.*);
  pmc_nbr_model #(.IN_W(IN_W)) pmc_nbr_model_inst (.clk_sys_i(clk_sys_i), .lin_o(lin_i),
    .lclr_o(lclr_i), .gclr_o(gclr_i), .clken_o(clken_i));

  // 40 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  // ==========================================
  // Tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // Request held until pready is seen high at a rising edge
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    rd_data = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    cmp({31'h0, rd_err}, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
    xfer(1'b0, a, 32'h0);
    cmp(rd_data, exp);
    cmp({31'h0, rd_err}, {31'h0, e});
  endtask
  task automatic st(input logic [IN_W-1:0] l, input logic [1:0] lc, input logic [1:0] gc,
                    input logic ce, input logic [MC_N-1:0] exp);
    pmc_nbr_model_inst.put(l, lc, gc, ce);
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmp(32'(mc_out_o), 32'(exp));
  endtask
  task automatic final_report();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h0;
    pwdata_i = 32'h0;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(12'h000, 32'h1, 1'b0);
    rd(12'h100, 32'h0, 1'b0);
    rd(12'h102, 32'h0, 1'b1);
    rd(12'hFFC, 32'h0, 1'b1);
    $display("test reset done");
    wr(12'h200, 32'h3);
    wr(12'h204, 32'h10);
    st(16'h3, 2'h0, 2'h0, 1'b1, 16'h1);
    st(16'h10, 2'h0, 2'h0, 1'b1, 16'h1);
    st(16'h0, 2'h0, 2'h0, 1'b1, 16'h0);
    wr(12'h100, 32'h8);
    st(16'h0, 2'h0, 2'h0, 1'b1, 16'h1);
    st(16'h3, 2'h0, 2'h0, 1'b1, 16'h0);
    $display("test terms done");
    for (int i = 0; i < 16; i++) begin
      wr(12'h100 + 12'(4 * i), i == 0 ? 32'h6 : i < 15 ? 32'h26 : 32'h10);
    end
    for (int k = 0; k < 32; k++) wr(12'h200 + 12'(4 * k), 32'h1 << (k % 16));
    for (int j = 0; j < 16; j++) st(16'h1 << j, 2'h0, 2'h0, 1'b1, 16'h8000);
    st(16'h0, 2'h0, 2'h0, 1'b1, 16'h0);
    $display("test expanders done");
    wr(12'h13C, 32'h11);
    st(16'h1, 2'h0, 2'h0, 1'b0, 16'h0);
    st(16'h1, 2'h0, 2'h0, 1'b1, 16'h8000);
    st(16'h0, 2'h0, 2'h0, 1'b0, 16'h8000);
    wr(12'h13C, 32'h91);
    st(16'h0, 2'h0, 2'h1, 1'b0, 16'h0);
    st(16'h1, 2'h0, 2'h0, 1'b1, 16'h8000);
    wr(12'h13C, 32'h111);
    st(16'h1, 2'h0, 2'h1, 1'b1, 16'h8000);
    st(16'h1, 2'h0, 2'h2, 1'b1, 16'h0);
    wr(12'h000, 32'h11);
    st(16'h1, 2'h0, 2'h2, 1'b1, 16'h8000);
    st(16'h1, 2'h0, 2'h0, 1'b1, 16'h0);
    wr(12'h000, 32'h9);
    st(16'h1, 2'h0, 2'h2, 1'b1, 16'h8000);
    st(16'h1, 2'h2, 2'h0, 1'b1, 16'h0);
    wr(12'h13C, 32'h151);
    st(16'h1, 2'h2, 2'h0, 1'b1, 16'h8000);
    rd(12'h004, 32'h8000, 1'b0);
    rd(12'h008, 32'h0, 1'b0);
    st(16'h0, 2'h0, 2'h0, 1'b1, 16'h0);
    wr(12'h000, 32'h0);
    st(16'h1, 2'h0, 2'h0, 1'b1, 16'h0);
    rd(12'h008, 32'h8000, 1'b0);
    $display("test register done");
    final_report();
  end
endmodule
